// File: hdl/ebr_pkg.sv
// ebr_pkg: constants, types and helpers of the embedded RAM block
// What this block does
// R1: True dual-port mode lets both ports read or write in the same cycle.
// R2: Simple dual-port takes a read and a write at once; a hit is old or junk.
// R3: Single-port write data shows on q at once, or an edge later if q is reg.
// R4: Write and read ports of a dual-port setup may use different widths.
// R5: Port inputs are registered, except port B in flow-through; the write strobe is made internally.
// R6: The read output register can be used or bypassed.
// R7: Simple dual-port can read flow-through, with no input or output stage.
// R8: The array can hold two independent single-port memories of half size.
// R9: No preload; as a ROM, user logic writes it once, then stops writing.
// R10: Wider memories are parallel blocks sharing addresses, no extra logic.
// R11: Input clear empties the input stage at once; output clear shows immediately.
// R12: Each stored byte carries one extra parity or control bit.
// R13: On x9..x36 ports, per-byte write enables mask which bytes are written; x1..x4 writes ignore them.
// R14: Narrow-port low address bits pick the lane, lane zero at the LSBs.
// R15: Address width is log2 of the depth; data width includes parity bits.
package ebr_pkg;

  localparam int DW    = 36;   // word and port width, parity included
  localparam int AW    = 12;   // port address, deepest setup 4K x 1
  localparam int WAW   = 7;    // array word address
  localparam int DEPTH = 128;
  localparam int BEW   = 4;
  localparam int CNT_W = 16;

  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SIMPLE = 2'h1;
  localparam logic [1:0] MODE_TRUE   = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  localparam logic [2:0] WID_X1  = 3'h0;
  localparam logic [2:0] WID_X2  = 3'h1;
  localparam logic [2:0] WID_X4  = 3'h2;
  localparam logic [2:0] WID_X9  = 3'h3;
  localparam logic [2:0] WID_X18 = 3'h4;
  localparam logic [2:0] WID_X36 = 3'h5;

  localparam logic [11:0]   ADDR_CTRL = 12'h000;
  localparam logic [11:0]   ADDR_STAT = 12'h004;
  localparam logic [DW-1:0] RDW_JUNK  = 36'hF_FFFF_FFFF;

  typedef struct packed {
    logic [2:0] wid_b;
    logic [2:0] wid_a;
    logic       old;
    logic       flow;
    logic       oreg_b;
    logic       oreg_a;
    logic [1:0] mode;
  } ebr_ctrl_s;

  localparam int        CTRL_W   = 12;
  localparam ebr_ctrl_s CTRL_RST = 12'hB40;

  typedef struct packed {
    logic           en;
    logic           we;
    logic [BEW-1:0] be;
    logic [AW-1:0]  addr;
    logic [DW-1:0]  wdata;
  } ebr_req_s;

  function automatic int ebr_width(input logic [2:0] code);
    case (code)
      WID_X1:  return 1;
      WID_X2:  return 2;
      WID_X4:  return 4;
      WID_X9:  return 9;
      WID_X18: return 18;
      default: return 36;
    endcase
  endfunction : ebr_width

  // lane index bits; x1..x4 pack 32 data bits, x9..x36 use parity too
  function automatic logic [2:0] ebr_shift(input logic [2:0] code);
    return (code > WID_X36) ? 3'h0 : 3'(3'h5 - code); // R15
  endfunction : ebr_shift

  function automatic logic [WAW-1:0] ebr_word(input logic [2:0]    code,
                                              input logic [AW-1:0] addr);
    return WAW'(addr >> ebr_shift(code));
  endfunction : ebr_word

  function automatic logic [4:0] ebr_lane(input logic [2:0]    code,
                                          input logic [AW-1:0] addr);
    return addr[4:0] & 5'((1 << ebr_shift(code)) - 1); // R14
  endfunction : ebr_lane

  // narrow data skips the parity bit of each byte
  function automatic int ebr_pos(input logic [2:0] code,
                                 input logic [4:0] lane,
                                 input int         i);
    int k;
    k = int'(lane) * ebr_width(code) + i;
    if (code < WID_X9) return 9 * (k / 8) + k % 8; // R12
    return k;
  endfunction : ebr_pos

  function automatic logic [DW-1:0] ebr_extract(input logic [DW-1:0] word,
                                                input logic [2:0]    code,
                                                input logic [4:0]    lane);
    logic [DW-1:0] q;
    q = '0;
    for (int i = 0; i < DW; i++)
      if (i < ebr_width(code)) q[i] = word[ebr_pos(code, lane, i)];
    return q;
  endfunction : ebr_extract

  // returns {bit mask, placed data}
  function automatic logic [2*DW-1:0] ebr_place(input logic [2:0]     code,
                                                input logic [4:0]     lane,
                                                input logic [BEW-1:0] be,
                                                input logic [DW-1:0]  d);
    logic [DW-1:0] m;
    logic [DW-1:0] v;
    int            p;
    m = '0;
    v = '0;
    p = 0;
    for (int i = 0; i < DW; i++)
      if (i < ebr_width(code)) begin
        p    = ebr_pos(code, lane, i);
        m[p] = (code < WID_X9) || be[i / 9]; // R13
        v[p] = d[i];
      end
    return {m, v};
  endfunction : ebr_place

endpackage : ebr_pkg

// File: hdl/ebr_array.sv
// ebr_array: 128 x 36 two-port storage with registered lane reads
module ebr_array (
  input  wire logic                      clk,     // port clock
  input  wire logic                      rclr_n,  // read register clear
  input  wire logic                      wr_a,    // port A write strobe
  input  wire logic                      ld_a,    // port A q load
  input  wire logic                      junk_a,  // port A collision
  input  wire logic [ebr_pkg::WAW-1:0]   wa_a,    // port A word
  input  wire logic [ebr_pkg::DW-1:0]    wm_a,    // port A bit mask
  input  wire logic [ebr_pkg::DW-1:0]    wd_a,    // port A placed data
  input  wire logic [2:0]                code_a,  // port A width code
  input  wire logic [4:0]                lane_a,  // port A lane
  output logic      [ebr_pkg::DW-1:0]    q_a,     // port A read data
  input  wire logic                      wr_b,    // port B write strobe
  input  wire logic                      ld_b,    // port B q load
  input  wire logic                      junk_b,  // port B collision
  input  wire logic [ebr_pkg::WAW-1:0]   wa_b,    // port B word
  input  wire logic [ebr_pkg::DW-1:0]    wm_b,    // port B bit mask
  input  wire logic [ebr_pkg::DW-1:0]    wd_b,    // port B placed data
  input  wire logic [2:0]                code_b,  // port B width code
  input  wire logic [4:0]                lane_b,  // port B lane
  output logic      [ebr_pkg::DW-1:0]    q_b      // port B read data
);
  import ebr_pkg::*;

  // no preload: contents come only from writes
  logic [DW-1:0] mem [DEPTH]; // R9 R12
  logic [DW-1:0] cur_a;
  logic [DW-1:0] cur_b;
  logic [DW-1:0] next_q_a;
  logic [DW-1:0] next_q_b;

  // own-port write shows through; the other port still sees old data
  always_comb begin
    cur_a = mem[wa_a];
    cur_b = mem[wa_b];
    if (wr_a) cur_a = (cur_a & ~wm_a) | (wd_a & wm_a); // R3
    if (wr_b) cur_b = (cur_b & ~wm_b) | (wd_b & wm_b);
    next_q_a = junk_a ? RDW_JUNK : ebr_extract(cur_a, code_a, lane_a);
    next_q_b = junk_b ? RDW_JUNK : ebr_extract(cur_b, code_b, lane_b);
  end

  // same word written by both ports: port B lands last
  always_ff @(posedge clk) begin
    if (wr_a) mem[wa_a] <= (mem[wa_a] & ~wm_a) | (wd_a & wm_a);
    if (wr_b) mem[wa_b] <= (mem[wa_b] & ~wm_b) | (wd_b & wm_b);
  end

  always_ff @(posedge clk or negedge rclr_n) begin
    if (!rclr_n) begin
      q_a <= '0; // R11
      q_b <= '0;
    end else begin
      if (ld_a) q_a <= next_q_a;
      if (ld_b) q_b <= next_q_b;
    end
  end

endmodule : ebr_array

// File: hdl/ebr_block.sv
// ebr_block: embedded RAM block, APB control and two user ports
module ebr_block (
  input  wire logic                    pclk,      // bus and port clock
  input  wire logic                    presetn,   // async reset, low
  input  wire logic [11:0]             paddr,     // APB address
  input  wire logic                    psel,      // APB select
  input  wire logic                    penable,   // APB enable
  input  wire logic                    pwrite,    // APB direction
  input  wire logic [31:0]             pwdata,    // APB write data
  output logic      [31:0]             prdata,    // APB read data
  output logic                         pready,    // APB ready
  output logic                         pslverr,   // APB error
  input  wire logic                    in_clr_n,  // input reg clear
  input  wire logic                    out_clr_n, // output reg clear
  input  wire ebr_pkg::ebr_req_s       req_a,     // port A request
  input  wire ebr_pkg::ebr_req_s       req_b,     // port B request
  output logic      [ebr_pkg::DW-1:0]  q_a,       // port A read data
  output logic      [ebr_pkg::DW-1:0]  q_b        // port B read data
);
  import ebr_pkg::*;

  ebr_ctrl_s        ctrl;
  ebr_ctrl_s        next_ctrl;
  logic [CNT_W-1:0] wr_cnt;
  logic [CNT_W-1:0] rd_cnt;
  logic [CNT_W-1:0] next_wr_cnt;
  logic [CNT_W-1:0] next_rd_cnt;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic             in_rst_n;
  logic             out_rst_n;
  ebr_req_s         req_a_q;
  ebr_req_s         req_b_q;
  ebr_req_s         iss_a;
  ebr_req_s         iss_b;
  logic             flow;
  logic             wr_a;
  logic             wr_b;
  logic             rd_a;
  logic             rd_b;
  logic [WAW-1:0]   wa_a;
  logic [WAW-1:0]   wa_b;
  logic [4:0]       lane_a;
  logic [4:0]       lane_b;
  logic [DW-1:0]    wm_a;
  logic [DW-1:0]    wd_a;
  logic [DW-1:0]    wm_b;
  logic [DW-1:0]    wd_b;
  logic             junk_a;
  logic             junk_b;
  logic [DW-1:0]    mem_q_a;
  logic [DW-1:0]    mem_q_b;
  logic [DW-1:0]    oq_a;
  logic [DW-1:0]    oq_b;

  // clears ride on the reset tree; both act without the clock
  assign in_rst_n  = presetn & in_clr_n;
  assign out_rst_n = presetn & out_clr_n;

  // register bus: answer registered in setup, so no wait states
  always_comb begin
    next_ctrl    = ctrl;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      unique case (paddr)
        ADDR_CTRL: next_prdata = 32'(ctrl);
        ADDR_STAT: next_prdata = {rd_cnt, wr_cnt};
        default: begin
          next_prdata  = '0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      next_ctrl = ebr_ctrl_s'(pwdata[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= CTRL_RST;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // every port input is captured; the write strobe comes from it
  always_ff @(posedge pclk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      req_a_q <= '0; // R11
      req_b_q <= '0;
    end else begin
      req_a_q <= req_a; // R5
      req_b_q <= req_b;
    end
  end

  // issue stage: mode gating, address split, lane placement
  always_comb begin
    flow  = ctrl.flow && (ctrl.mode == MODE_SIMPLE);
    iss_a = req_a_q;
    // flow-through reads skip the input stage, like a falling-edge capture
    iss_b = flow ? req_b : req_b_q; // R7
    wr_a  = iss_a.en && iss_a.we; // R5
    rd_a  = iss_a.en && !iss_a.we && (ctrl.mode != MODE_SIMPLE);
    wr_b  = iss_b.en && iss_b.we &&
            (ctrl.mode == MODE_TRUE || ctrl.mode == MODE_SPLIT); // R1
    rd_b  = iss_b.en && !iss_b.we && (ctrl.mode != MODE_SINGLE); // R2
    // addresses go straight to the array, so blocks can sit side by side
    wa_a  = ebr_word(ctrl.wid_a, iss_a.addr); // R10 R15
    wa_b  = ebr_word(ctrl.wid_b, iss_b.addr);
    if (ctrl.mode == MODE_SPLIT) begin
      wa_a[WAW-1] = 1'b0; // R8
      wa_b[WAW-1] = 1'b1;
    end
    lane_a = ebr_lane(ctrl.wid_a, iss_a.addr); // R14
    lane_b = ebr_lane(ctrl.wid_b, iss_b.addr);
    {wm_a, wd_a} = ebr_place(ctrl.wid_a, lane_a, iss_a.be,
                             iss_a.wdata); // R4 R13
    {wm_b, wd_b} = ebr_place(ctrl.wid_b, lane_b, iss_b.be,
                             iss_b.wdata);
    // cross-port hit on one word: old data or junk, as configured
    junk_a = rd_a && wr_b && (wa_a == wa_b) && !ctrl.old; // R2
    junk_b = rd_b && wr_a && (wa_a == wa_b) && !ctrl.old;
  end

  ebr_array u_array (
    .clk    (pclk),
    .rclr_n (out_rst_n),
    .wr_a   (wr_a),
    .ld_a   (rd_a || wr_a),
    .junk_a (junk_a),
    .wa_a   (wa_a),
    .wm_a   (wm_a),
    .wd_a   (wd_a),
    .code_a (ctrl.wid_a),
    .lane_a (lane_a),
    .q_a    (mem_q_a),
    .wr_b   (wr_b),
    .ld_b   (rd_b || wr_b),
    .junk_b (junk_b),
    .wa_b   (wa_b),
    .wm_b   (wm_b),
    .wd_b   (wd_b),
    .code_b (ctrl.wid_b),
    .lane_b (lane_b),
    .q_b    (mem_q_b)
  );

  // activity counters for software, wrap silently
  always_comb begin
    next_wr_cnt = wr_cnt + CNT_W'(wr_a) + CNT_W'(wr_b);
    next_rd_cnt = rd_cnt + CNT_W'(rd_a) + CNT_W'(rd_b);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt <= '0;
      rd_cnt <= '0;
    end else begin
      wr_cnt <= next_wr_cnt;
      rd_cnt <= next_rd_cnt;
    end
  end

  // output stage; clear is seen on q without waiting for an edge
  always_ff @(posedge pclk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      oq_a <= '0; // R11
      oq_b <= '0;
    end else begin
      oq_a <= mem_q_a;
      oq_b <= mem_q_b;
    end
  end

  // bypass trades a cycle of latency for a longer array path
  assign q_a = ctrl.oreg_a ? oq_a : mem_q_a; // R6
  assign q_b = (ctrl.oreg_b && !flow) ? oq_b : mem_q_b; // R6 R7

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_sync_write;
    req_a.en && req_a.we && in_clr_n ##1 in_clr_n |-> wr_a;
  endproperty
  a_sync_write: assert property (p_sync_write) // R5
    else $error("registered write did not strobe the array");

  property p_flow;
    ctrl.flow && ctrl.mode == MODE_SIMPLE && req_b.en && !req_b.we
      && out_clr_n ##1 out_clr_n |-> q_b == mem_q_b
      && mem_q_b == ($past(junk_b) ? RDW_JUNK : ebr_extract(
           $past(u_array.cur_b), $past(ctrl.wid_b), $past(lane_b)));
  endproperty
  a_flow: assert property (p_flow) // R7
    else $error("flow-through read not on q one edge later");

  property p_rdw_junk;
    rd_b && wr_a && wa_a == wa_b && !ctrl.old ##1 out_clr_n
      |-> mem_q_b == RDW_JUNK;
  endproperty
  a_rdw_junk: assert property (p_rdw_junk) // R2
    else $error("colliding read did not return junk");

  property p_wr_through;
    ctrl.mode == MODE_SINGLE && !ctrl.oreg_a && ctrl.wid_a == WID_X36
      && req_a.en && req_a.we && (&req_a.be) && in_clr_n
      ##1 in_clr_n && $stable(ctrl) ##1 out_clr_n
      |-> q_a == $past(req_a.wdata, 2);
  endproperty
  a_wr_through: assert property (p_wr_through) // R3
    else $error("written word not on unregistered q");

  property p_out_reg;
    ctrl.oreg_a && out_clr_n && $past(out_clr_n)
      |-> q_a == $past(mem_q_a);
  endproperty
  a_out_reg: assert property (p_out_reg) // R6
    else $error("registered q does not lag the array by one");

  property p_out_clear;
    !out_clr_n |-> q_a == '0 && q_b == '0;
  endproperty
  a_out_clear: assert property (p_out_clear) // R11
    else $error("output clear not visible on q");

  property p_split_half;
    ctrl.mode == MODE_SPLIT |-> !wa_a[WAW-1] && wa_b[WAW-1];
  endproperty
  a_split_half: assert property (p_split_half) // R8
    else $error("split memories share a half");

  property p_byte_en;
    wr_a && ctrl.wid_a == WID_X36 && !iss_a.be[1] |-> wm_a[17:9] == '0;
  endproperty
  a_byte_en: assert property (p_byte_en) // R13
    else $error("disabled byte was written");

  property p_lane0;
    wr_a && ctrl.wid_a == WID_X1 && iss_a.addr[4:0] == 5'h00
      |-> wm_a == 36'h0_0000_0001;
  endproperty
  a_lane0: assert property (p_lane0) // R14
    else $error("lane zero not at the low bit");

  property p_two_writes;
    (ctrl.mode == MODE_TRUE || ctrl.mode == MODE_SPLIT)
      && iss_a.en && iss_a.we && iss_b.en && iss_b.we |-> wr_a && wr_b;
  endproperty
  a_two_writes: assert property (p_two_writes) // R1
    else $error("true dual-port dropped a write");

  property p_addr_width;
    ctrl.wid_a == WID_X36 && ctrl.mode != MODE_SPLIT
      |-> wa_a == iss_a.addr[WAW-1:0];
  endproperty
  a_addr_width: assert property (p_addr_width) // R15
    else $error("x36 port word address wrong");

  property p_in_clear;
    !in_clr_n |-> !wr_a && !rd_a;
  endproperty
  a_in_clear: assert property (p_in_clear) // R11
    else $error("request survived the input clear");

  property p_parity_skip;
    wr_a && ctrl.wid_a < WID_X9
      |-> !wm_a[8] && !wm_a[17] && !wm_a[26] && !wm_a[35];
  endproperty
  a_parity_skip: assert property (p_parity_skip) // R12
    else $error("narrow write touched a parity bit");

  property p_lane_x9;
    wr_a && ctrl.wid_a == WID_X9 && iss_a.addr[1:0] == 2'h3
      |-> wm_a == (iss_a.be[0] ? 36'hF_F800_0000 : 36'h0_0000_0000);
  endproperty
  a_lane_x9: assert property (p_lane_x9) // R14
    else $error("top x9 lane not at the high bits");

  property p_x18_word;
    ctrl.wid_b == WID_X18 && ctrl.mode != MODE_SPLIT
      |-> wa_b == iss_b.addr[7:1];
  endproperty
  a_x18_word: assert property (p_x18_word) // R15
    else $error("x18 port word address wrong");

  property p_true_mixed;
    ctrl.mode == MODE_TRUE && iss_a.en && !iss_a.we && iss_b.en && iss_b.we
      |-> rd_a && wr_b;
  endproperty
  a_true_mixed: assert property (p_true_mixed) // R1
    else $error("true dual-port dropped a read or write");

  c_flow:  cover property (flow && rd_b);
  c_junk:  cover property (junk_b);
  c_split: cover property (ctrl.mode == MODE_SPLIT && wr_a && wr_b);
  c_mixed: cover property (wr_a && rd_b && ctrl.wid_a != ctrl.wid_b);
  c_clear: cover property (!in_clr_n && req_a.en);

endmodule : ebr_block

// File: tb/ebr_user.sv
// ebr_user: user fabric logic driving one port of the RAM block
module ebr_user (
  input  wire logic        pclk, // port clock
  output ebr_pkg::ebr_req_s req   // port request
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebr_pkg::*;

  initial req = '0;

  // held across its sampling edge, then inverted so stale fields never
  // look like a live request
  task automatic op(input logic           we,
                    input logic [BEW-1:0] be,
                    input logic [AW-1:0]  a,
                    input logic [DW-1:0]  d);
    ebr_req_s r;
    r = '{en: 1'b1, we: we, be: be, addr: a, wdata: d};
    @(posedge pclk);
    req <= r;
    @(posedge pclk);
    r = ~r;
    r.en = 1'b0;
    req <= r;
  endtask : op
endmodule : ebr_user

// File: tb/test_ebr_block.sv
// test_ebr_block: directed bench for the embedded RAM block
module test_ebr_block;
  timeunit 1ns;
  timeprecision 1ps;
  import ebr_pkg::*;

  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          in_clr_n, out_clr_n, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  ebr_req_s      req_a, req_b;
  logic [DW-1:0] q_a, q_b, e;
  int            errors, comparisons, cycles;

  ebr_block dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_clr_n(in_clr_n), .out_clr_n(out_clr_n), .req_a(req_a),
    .req_b(req_b), .q_a(q_a), .q_b(q_b));
  ebr_user ua (.pclk(pclk), .req(req_a));
  ebr_user ub (.pclk(pclk), .req(req_b));

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check_data(input logic [DW-1:0] got,
                            input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  // f packs old, flow, oreg_b, oreg_a from high to low
  function automatic logic [31:0] cfg(input logic [1:0] m,
                                      input logic [3:0] f,
                                      input logic [2:0] wa,
                                      input logic [2:0] wb);
    return {20'h0, wb, wa, f, m};
  endfunction : cfg

  task automatic complete_run;
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    in_clr_n = 1'b1;
    out_clr_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check_data(36'(rd), 36'(CTRL_RST));
    check_bit(err, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    check_bit(err, 1'b1);
    check_data(36'(rd), 36'h0);
    apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_STAT, 32'h0);
    check_data(36'(rd), 36'h0);
    // single-port, bypass: write shows on the next cycle
    ua.op(1'b1, 4'hF, 12'h003, 36'h1_2345_6789);
    settle(1);
    check_data(q_a, 36'h1_2345_6789);
    fork
      ua.op(1'b0, 4'h0, 12'h003, 36'h0);
      ub.op(1'b1, 4'hF, 12'h003, 36'h0);
    join
    settle(1);
    check_data(q_a, 36'h1_2345_6789);
    apb(1'b1, ADDR_CTRL, cfg(MODE_SINGLE, 4'h1, WID_X36, WID_X36));
    ua.op(1'b1, 4'hF, 12'h004, 36'h2_0000_0002);
    settle(1);
    check_data(q_a, 36'h1_2345_6789);
    settle(1);
    check_data(q_a, 36'h2_0000_0002);
    apb(1'b1, ADDR_CTRL, cfg(MODE_TRUE, 4'h8, WID_X36, WID_X36));
    fork
      ua.op(1'b1, 4'hF, 12'h003, 36'h3_3333_3333);
      ub.op(1'b0, 4'h0, 12'h003, 36'h0);
    join
    settle(1);
    check_data(q_b, 36'h1_2345_6789);
    check_data(q_a, 36'h3_3333_3333);
    fork
      ua.op(1'b0, 4'h0, 12'h003, 36'h0);
      ub.op(1'b1, 4'hF, 12'h007, 36'h4_4444_4444);
    join
    settle(1);
    check_data(q_a, 36'h3_3333_3333);
    check_data(q_b, 36'h4_4444_4444);
    ua.op(1'b1, 4'h5, 12'h007, 36'hA_AAAA_AAAA);
    ub.op(1'b0, 4'h0, 12'h007, 36'h0);
    settle(1);
    e = (36'hA_AAAA_AAAA & 36'h0_07FC_01FF)
      | (36'h4_4444_4444 & ~36'h0_07FC_01FF);
    check_data(q_b, e);
    apb(1'b1, ADDR_CTRL, cfg(MODE_SIMPLE, 4'h0, WID_X36, WID_X36));
    fork
      ua.op(1'b1, 4'hF, 12'h003, 36'h5_5555_5555);
      ub.op(1'b0, 4'h0, 12'h003, 36'h0);
    join
    settle(1);
    check_data(q_b, RDW_JUNK);
    // x9 lanes into word 9, read back whole and as x18
    apb(1'b1, ADDR_CTRL, cfg(MODE_SIMPLE, 4'h0, WID_X9, WID_X36));
    for (int i = 0; i < 4; i++) begin
      ua.op(1'b1, 4'h1, 12'(36 + i), 36'(9'h1A0 + 9'(i)));
      e[9*i +: 9] = 9'h1A0 + 9'(i);
    end
    ub.op(1'b0, 4'h0, 12'h009, 36'h0);
    settle(1);
    check_data(q_b, e);
    apb(1'b1, ADDR_CTRL, cfg(MODE_SIMPLE, 4'h0, WID_X1, WID_X18));
    ub.op(1'b0, 4'h0, 12'h013, 36'h0);
    settle(1);
    check_data(q_b, 36'(e[35:18]));
    // x1 bit 8 lands past the parity bit of byte 0
    ua.op(1'b1, 4'h0, 12'(9 * 32 + 8), 36'h0);
    e[9] = 1'b0;
    ua.op(1'b1, 4'h0, 12'(9 * 32), 36'h1);
    e[0] = 1'b1;
    apb(1'b1, ADDR_CTRL, cfg(MODE_SIMPLE, 4'h0, WID_X1, WID_X36));
    ub.op(1'b0, 4'h0, 12'h009, 36'h0);
    settle(1);
    check_data(q_b, e);
    apb(1'b1, ADDR_CTRL, cfg(MODE_SIMPLE, 4'h6, WID_X36, WID_X36));
    ub.op(1'b0, 4'h0, 12'h003, 36'h0);
    #1;
    check_data(q_b, 36'h5_5555_5555);
    apb(1'b1, ADDR_CTRL, cfg(MODE_SPLIT, 4'h0, WID_X36, WID_X36));
    fork
      ua.op(1'b1, 4'hF, 12'h005, 36'h6_6666_6666);
      ub.op(1'b1, 4'hF, 12'h005, 36'h7_7777_7777);
    join
    fork
      ua.op(1'b0, 4'h0, 12'h005, 36'h0);
      ub.op(1'b0, 4'h0, 12'h005, 36'h0);
    join
    settle(1);
    check_data(q_a, 36'h6_6666_6666);
    check_data(q_b, 36'h7_7777_7777);
    @(posedge pclk);
    out_clr_n <= 1'b0;
    #1;
    check_data(q_a, 36'h0);
    check_data(q_b, 36'h0);
    @(posedge pclk);
    out_clr_n <= 1'b1;
    // a request captured while input clear is low must be dropped
    fork
      ua.op(1'b0, 4'h0, 12'h005, 36'h0);
      begin
        @(posedge pclk);
        in_clr_n <= 1'b0;
        @(posedge pclk);
        in_clr_n <= 1'b1;
      end
    join
    settle(2);
    check_data(q_a, 36'h0);
    complete_run();
  end
endmodule : test_ebr_block
